// file: pmsc_regs.svh
// register map, field positions and reset values of the supply status and control bank
`ifndef PMSC_REGS_SVH
`define PMSC_REGS_SVH
// register offsets
`define PMSC_ADDR_VERSION 8'h00
`define PMSC_ADDR_STATUS 8'h01
`define PMSC_ADDR_MASK 8'h02
`define PMSC_ADDR_ENABLE 8'h03
`define PMSC_ADDR_CONV 8'h04
// reset and fixed values
`define PMSC_RST_MASK 8'hc0
`define PMSC_RST_ENABLE 8'hff
`define PMSC_RST_CONV 8'hb1
`define PMSC_UNMAPPED 8'hff
`define PMSC_LIVE_BITS 8'hfe
`define PMSC_EN_FIXED 8'hc1
`define PMSC_VERSION_DEF 8'h5a
// serial bus
`define PMSC_BUS_ADDR 7'h48
`define PMSC_BYTE_BITS 4'h8
`define PMSC_LAST_BIT 4'h7
// status, mask and enable bit positions
`define PMSC_B_PF 7
`define PMSC_B_LB 6
`define PMSC_B_BUCK1 5
`define PMSC_B_BUCK2 4
`define PMSC_B_CORE 3
`define PMSC_B_LIN2 2
`define PMSC_B_LIN1 1
// converter mode fields
`define PMSC_F_PH2 7:6
`define PMSC_F_PHC 5:4
`define PMSC_F_LOWRIP 3
`define PMSC_F_FFF2 2
`define PMSC_F_FFF1 1
`define PMSC_F_FFFC 0
// positions in the synchronised pin vector
`define PMSC_IN_PF 0
`define PMSC_IN_LB 1
`define PMSC_IN_LOW1 2
`define PMSC_IN_LOW2 3
`define PMSC_IN_LOWC 4
`define PMSC_IN_LOWL1 5
`define PMSC_IN_LOWL2 6
`define PMSC_IN_DVM 7
`define PMSC_IN_UNDERVOLTAGE_LOCKOUT 8
`define PMSC_IN_PIN1 9
`define PMSC_IN_PIN2 10
`define PMSC_IN_PINC 11
`define PMSC_IN_PINL 12
`define PMSC_IN_W 13
`endif

// file: pmsc_pkg.sv
// types shared by the register bank and its serial slave
package pmsc_pkg;
   `include "pmsc_regs.svh"

   // serial slave phases
   typedef enum logic [2:0] {
      TW_IDLE,
      TW_RX,
      TW_RXACK,
      TW_TX,
      TW_TXACK,
      TW_TXLOAD
   } pmsc_twi_state_type;

   // whole state of the serial slave
   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      logic [1:0] s3;
      logic [1:0] f;
      pmsc_twi_state_type st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] ptr;
      logic first;
      logic ptr_next;
      logic dat;
      logic rw;
      logic oe;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } pmsc_twi_regs_type;

   // whole state of the register bank
   typedef struct packed {
      logic [`PMSC_IN_W-1:0] s1;
      logic [`PMSC_IN_W-1:0] s2;
      logic [`PMSC_IN_W-1:0] s3;
      logic [`PMSC_IN_W-1:0] f;
      logic [7:0] mask;
      logic [7:0] en;
      logic [7:0] conv;
      logic [7:0] stat;
      logic [7:0] block;
      logic b1_en;
      logic b2_en;
      logic c_en;
      logic l1_en;
      logic l2_en;
      logic int_n;
   } pmsc_bank_regs_type;
endpackage : pmsc_pkg

// file: pmsc_twi_slave.sv
// two-wire serial slave: pointer byte, auto-incremented register writes and reads
`timescale 1ns/10ps
`include "pmsc_regs.svh"
module pmsc_twi_slave (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // serial pins, data line is open drain
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_oe_o,
   // register side
   input wire logic [7:0] rdata_i,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   output logic wr_stb_o,
   output logic rd_stb_o
);
   import pmsc_pkg::*;

   pmsc_twi_regs_type r;
   pmsc_twi_regs_type n;

   // next state: pin filter, start/stop detection, byte engine
   always_comb begin
      logic rise;
      logic fall;
      logic start;
      logic stop;
      logic load;
      rise = 1'b0;
      fall = 1'b0;
      start = 1'b0;
      stop = 1'b0;
      load = 1'b0;
      n = r;
      n.wr = 1'b0;
      n.rd = 1'b0;
      n.s1 = {scl_i, sda_i};
      n.s2 = r.s1;
      n.s3 = r.s2;
      // a change counts once stages two and three agree
      n.f = (r.s2 & r.s3) | (r.f & (r.s2 ^ r.s3));
      rise = n.f[1] & ~r.f[1];
      fall = ~n.f[1] & r.f[1];
      start = r.f[1] & n.f[1] & r.f[0] & ~n.f[0];
      stop = r.f[1] & n.f[1] & ~r.f[0] & n.f[0];
      if (start) begin
         n.st = TW_RX;
         n.cnt = '0;
         n.first = 1'b1;
         n.oe = 1'b0;
      end else if (stop) begin
         n.st = TW_IDLE;
         n.oe = 1'b0;
      end else begin
         case (r.st)
            TW_RX: begin
               if (rise) begin
                  n.sh = {r.sh[6:0], n.f[0]};
                  n.cnt = 4'(r.cnt + 4'h1);
               end else if (fall && r.cnt == `PMSC_BYTE_BITS) begin
                  n.cnt = '0;
                  n.st = TW_RXACK;
                  n.oe = 1'b1;
                  if (r.first) begin
                     n.first = 1'b0;
                     n.rw = r.sh[0];
                     n.ptr_next = ~r.sh[0];
                     // a foreign address is not acknowledged
                     if (r.sh[7:1] != `PMSC_BUS_ADDR) begin
                        n.st = TW_IDLE;
                        n.oe = 1'b0;
                     end
                  end else if (r.ptr_next) begin
                     n.ptr = r.sh;
                     n.ptr_next = 1'b0;
                  end else begin
                     n.wr = 1'b1;
                     n.wdata = r.sh;
                     n.dat = 1'b1;
                  end
               end
            end
            TW_RXACK: begin
               if (fall) begin
                  // advance only after the write strobe used the old pointer
                  n.oe = 1'b0;
                  n.dat = 1'b0;
                  if (r.dat) begin
                     n.ptr = 8'(r.ptr + 8'h01);
                  end
                  if (r.rw) begin
                     load = 1'b1;
                  end else begin
                     n.st = TW_RX;
                  end
               end
            end
            TW_TXLOAD: begin
               if (fall) begin
                  load = 1'b1;
               end
            end
            TW_TX: begin
               if (fall) begin
                  if (r.cnt == `PMSC_LAST_BIT) begin
                     n.oe = 1'b0;
                     n.st = TW_TXACK;
                  end else begin
                     n.cnt = 4'(r.cnt + 4'h1);
                     n.sh = {r.sh[6:0], 1'b0};
                     n.oe = ~r.sh[6];
                  end
               end
            end
            TW_TXACK: begin
               if (rise) begin
                  // a missing acknowledge ends the read
                  if (n.f[0]) begin
                     n.st = TW_IDLE;
                  end else begin
                     n.ptr = 8'(r.ptr + 8'h01);
                     n.st = TW_TXLOAD;
                  end
               end
            end
            default: begin
               n.st = TW_IDLE;
            end
         endcase
      end
      // fetch a byte and put its top bit on the line
      if (load) begin
         n.sh = rdata_i;
         n.rd = 1'b1;
         n.oe = ~rdata_i[7];
         n.cnt = '0;
         n.st = TW_TX;
      end
   end

   // state register; the idle bus level is high
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         r <= '{s1: 2'h3, s2: 2'h3, s3: 2'h3, f: 2'h3, st: TW_IDLE, default: '0};
      end else begin
         r <= n;
      end
   end

   assign sda_oe_o = r.oe;
   assign addr_o = r.ptr;
   assign wdata_o = r.wdata;
   assign wr_stb_o = r.wr;
   assign rd_stb_o = r.rd;
endmodule : pmsc_twi_slave

// file: pmsc_regs_top.sv
// supply status and control register bank behind the two-wire serial port
//
// Notes on behaviour
// - status bits 7 and 6 are one while power-fail or low-battery sense is high
// - buck status bits 5..3 show output below target, zero when disabled
// - core buck status bit is zero during a dynamic voltage move
// - linear status bits 2 and 1 show low output, zero when disabled
// - version register at 0x00 is read only, fixed code
// - status register at 0x01 is read only and follows live comparators
// - mask register at 0x02 is read/write, reset 0xc0
// - each buck runs only when its pin and enable bit are both high
// - each linear regulator needs shared pin high and its own bit set
// - enable register resets to 0xff
// - while an enable pin is low its enable bits are forced to one
// - bits 7:6 and 5:4 set buck two and core phase delay
// - bit 3 selects low-ripple skip tuning for all converters
// - bit 2 forces buck two into fixed-frequency operation
// - undervoltage lockout reloads mask, enable and mode defaults
// - bit 1 forces buck one, bit 0 the core buck, fixed-frequency
// - status bits active at a status read are blocked from the interrupt
// - reading an unimplemented address returns 0xff
// - interrupt is a power-ok line built from unmasked, unblocked flags
`timescale 1ns/10ps
`include "pmsc_regs.svh"
module pmsc_regs_top #(
   parameter logic [7:0] VERSION_CODE = `PMSC_VERSION_DEF // value is arbitrary
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // serial port, data line open drain
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // detector and comparator levels, high means below threshold
   input wire logic power_fail_sense_i,
   input wire logic low_battery_sense_i,
   input wire logic buck1_output_low_i,
   input wire logic buck2_output_low_i,
   input wire logic core_buck_output_low_i,
   input wire logic linear_reg_one_low_i,
   input wire logic linear_reg_two_low_i,
   // converter events
   input wire logic dynamic_voltage_move_i,
   input wire logic undervoltage_lockout_i,
   // enable pins
   input wire logic buck1_enable_pin_i,
   input wire logic buck2_enable_pin_i,
   input wire logic core_buck_enable_pin_i,
   input wire logic linear_enable_pin_i,
   // regulator enables
   output logic buck1_en_o,
   output logic buck2_en_o,
   output logic core_buck_en_o,
   output logic linear_reg_one_en_o,
   output logic linear_reg_two_en_o,
   // converter mode controls
   output logic [1:0] buck2_phase_o,
   output logic [1:0] core_buck_phase_o,
   output logic low_ripple_o,
   output logic buck1_forced_fixed_freq_o,
   output logic buck2_forced_fixed_freq_o,
   output logic core_buck_forced_fixed_freq_o,
   // power-ok interrupt, active low
   output logic int_n_o
);
   import pmsc_pkg::*;

   // bank state and its next value
   pmsc_bank_regs_type r;
   pmsc_bank_regs_type n;

   // register access from the serial slave
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic reg_wr;
   logic reg_rd;

   // raw levels from pins and comparators, not yet on our clock
   logic [`PMSC_IN_W-1:0] pin_raw;

   // strobe aimed at one register offset
   function automatic logic hit(input logic stb, input logic [7:0] a, input logic [7:0] off);
      return stb && (a == off);
   endfunction : hit

   // read decode; unmapped offsets read as all ones
   function automatic logic [7:0] read_value(
      input logic [7:0] a,
      input pmsc_bank_regs_type s
   );
      logic [7:0] v;
      v = `PMSC_UNMAPPED;
      case (a)
         `PMSC_ADDR_VERSION: begin
            v = VERSION_CODE;
         end
         `PMSC_ADDR_STATUS: begin
            v = s.stat;
         end
         `PMSC_ADDR_MASK: begin
            v = s.mask;
         end
         `PMSC_ADDR_ENABLE: begin
            v = s.en;
         end
         `PMSC_ADDR_CONV: begin
            v = s.conv;
         end
         default: begin
            v = `PMSC_UNMAPPED;
         end
      endcase
      return v;
   endfunction : read_value

   // gather the asynchronous inputs into one vector for the synchroniser
   assign pin_raw[`PMSC_IN_PF] = power_fail_sense_i;
   assign pin_raw[`PMSC_IN_LB] = low_battery_sense_i;
   assign pin_raw[`PMSC_IN_LOW1] = buck1_output_low_i;
   assign pin_raw[`PMSC_IN_LOW2] = buck2_output_low_i;
   assign pin_raw[`PMSC_IN_LOWC] = core_buck_output_low_i;
   assign pin_raw[`PMSC_IN_LOWL1] = linear_reg_one_low_i;
   assign pin_raw[`PMSC_IN_LOWL2] = linear_reg_two_low_i;
   assign pin_raw[`PMSC_IN_DVM] = dynamic_voltage_move_i;
   assign pin_raw[`PMSC_IN_UNDERVOLTAGE_LOCKOUT] = undervoltage_lockout_i;
   assign pin_raw[`PMSC_IN_PIN1] = buck1_enable_pin_i;
   assign pin_raw[`PMSC_IN_PIN2] = buck2_enable_pin_i;
   assign pin_raw[`PMSC_IN_PINC] = core_buck_enable_pin_i;
   assign pin_raw[`PMSC_IN_PINL] = linear_enable_pin_i;

   // read data is combinational so the slave can load it on the bus clock edge
   assign reg_rdata = read_value(reg_addr, r);

   // serial slave: pointer handling and byte shifting
   pmsc_twi_slave u_twi (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .sda_oe_o(sda_oe_o),
      .rdata_i(reg_rdata),
      .addr_o(reg_addr),
      .wdata_o(reg_wdata),
      .wr_stb_o(reg_wr),
      .rd_stb_o(reg_rd)
   );

   // next state of the bank
   always_comb begin
      logic [7:0] live;
      live = '0;
      n = r;

      // three flip-flops; a change counts once stages two and three agree
      n.s1 = pin_raw;
      n.s2 = r.s1;
      n.s3 = r.s2;
      n.f = (r.s2 & r.s3) | (r.f & (r.s2 ^ r.s3));

      // a supply runs only when its pin and its register bit are both high
      n.b1_en = r.f[`PMSC_IN_PIN1] & r.en[`PMSC_B_BUCK1];
      n.b2_en = r.f[`PMSC_IN_PIN2] & r.en[`PMSC_B_BUCK2];
      n.c_en = r.f[`PMSC_IN_PINC] & r.en[`PMSC_B_CORE];
      n.l2_en = r.f[`PMSC_IN_PINL] & r.en[`PMSC_B_LIN2];
      n.l1_en = r.f[`PMSC_IN_PINL] & r.en[`PMSC_B_LIN1];

      // status follows the live detectors; a disabled rail always reads good
      n.stat[`PMSC_B_PF] = r.f[`PMSC_IN_PF];
      n.stat[`PMSC_B_LB] = r.f[`PMSC_IN_LB];
      n.stat[`PMSC_B_BUCK1] = r.f[`PMSC_IN_LOW1] & r.b1_en;
      n.stat[`PMSC_B_BUCK2] = r.f[`PMSC_IN_LOW2] & r.b2_en;
      // the core rail is hidden while its voltage is being moved
      n.stat[`PMSC_B_CORE] = r.f[`PMSC_IN_LOWC] & r.c_en & ~r.f[`PMSC_IN_DVM];
      n.stat[`PMSC_B_LIN2] = r.f[`PMSC_IN_LOWL2] & r.l2_en;
      n.stat[`PMSC_B_LIN1] = r.f[`PMSC_IN_LOWL1] & r.l1_en;
      n.stat[0] = 1'b0;

      // host writes; version and status offsets take no write
      if (hit(reg_wr, reg_addr, `PMSC_ADDR_MASK)) begin
         n.mask = reg_wdata & `PMSC_LIVE_BITS;
      end
      if (hit(reg_wr, reg_addr, `PMSC_ADDR_ENABLE)) begin
         n.en = reg_wdata | `PMSC_EN_FIXED;
      end
      if (hit(reg_wr, reg_addr, `PMSC_ADDR_CONV)) begin
         n.conv = reg_wdata;
      end

      // a low pin keeps pushing its bits back to one, even over a write
      if (!r.f[`PMSC_IN_PIN1]) begin
         n.en[`PMSC_B_BUCK1] = 1'b1;
      end
      if (!r.f[`PMSC_IN_PIN2]) begin
         n.en[`PMSC_B_BUCK2] = 1'b1;
      end
      if (!r.f[`PMSC_IN_PINC]) begin
         n.en[`PMSC_B_CORE] = 1'b1;
      end
      if (!r.f[`PMSC_IN_PINL]) begin
         n.en[`PMSC_B_LIN2] = 1'b1;
         n.en[`PMSC_B_LIN1] = 1'b1;
      end

      // lockout reloads defaults and wins over a write in the same cycle
      if (r.f[`PMSC_IN_UNDERVOLTAGE_LOCKOUT]) begin
         n.mask = `PMSC_RST_MASK;
         n.en = `PMSC_RST_ENABLE;
         n.conv = `PMSC_RST_CONV;
      end

      // a status read blocks its active bits; a bit that clears is released
      n.block = r.block & r.stat;
      if (hit(reg_rd, reg_addr, `PMSC_ADDR_STATUS)) begin
         n.block = n.block | r.stat;
      end

      // power-ok line: low while any unmasked, unblocked flag stands
      live = r.stat & ~r.mask & ~r.block & `PMSC_LIVE_BITS;
      n.int_n = ~(|live);
   end

   // state register; defaults match the lockout values
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         r <= '{
            mask: `PMSC_RST_MASK,
            en: `PMSC_RST_ENABLE,
            conv: `PMSC_RST_CONV,
            int_n: 1'b1,
            default: '0
         };
      end else begin
         r <= n;
      end
   end

   // outputs straight from the state register
   assign buck1_en_o = r.b1_en;
   assign buck2_en_o = r.b2_en;
   assign core_buck_en_o = r.c_en;
   assign linear_reg_one_en_o = r.l1_en;
   assign linear_reg_two_en_o = r.l2_en;
   assign buck2_phase_o = r.conv[`PMSC_F_PH2];
   assign core_buck_phase_o = r.conv[`PMSC_F_PHC];
   assign low_ripple_o = r.conv[`PMSC_F_LOWRIP];
   assign buck2_forced_fixed_freq_o = r.conv[`PMSC_F_FFF2];
   assign buck1_forced_fixed_freq_o = r.conv[`PMSC_F_FFF1];
   assign core_buck_forced_fixed_freq_o = r.conv[`PMSC_F_FFFC];
   // open drain: the line is only ever pulled low, the enable does the work
   assign sda_o = 1'b0;
   assign int_n_o = r.int_n;

   // a low buck one pin must leave its enable bit set one cycle later
   pin_force_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      !r.f[`PMSC_IN_PIN1] |=> r.en[`PMSC_B_BUCK1])
   else $error("enable bit not held while its pin is low");

   // a running buck one needs both its pin and its bit
   buck_gate_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      buck1_en_o |-> $past(r.f[`PMSC_IN_PIN1] & r.en[`PMSC_B_BUCK1]))
   else $error("buck enabled without pin and bit");

   // lockout reloads all three control registers
   undervoltage_lockout_load_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      r.f[`PMSC_IN_UNDERVOLTAGE_LOCKOUT] |=> (r.mask == `PMSC_RST_MASK && r.en == `PMSC_RST_ENABLE
         && r.conv == `PMSC_RST_CONV))
   else $error("defaults not reloaded on lockout");

   // core flag stays clear during a voltage move
   dvm_clear_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      r.f[`PMSC_IN_DVM] |=> !r.stat[`PMSC_B_CORE])
   else $error("core flag set during voltage move");

   // an open flag pulls the interrupt low
   irq_low_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (|(r.stat & ~r.mask & ~r.block & `PMSC_LIVE_BITS)) |=> !int_n_o)
   else $error("interrupt not asserted for open flag");

   // no open flag leaves the interrupt released
   irq_high_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      !(|(r.stat & ~r.mask & ~r.block & `PMSC_LIVE_BITS)) |=> int_n_o)
   else $error("interrupt asserted with all flags masked or blocked");

   // a status read blocks every bit that was active
   read_block_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (reg_rd && reg_addr == `PMSC_ADDR_STATUS) |=> ((r.block & $past(r.stat)) == $past(r.stat)))
   else $error("status read did not block active bits");

   // unmapped offsets read as all ones
   unmapped_read_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (reg_addr > `PMSC_ADDR_CONV) |-> (reg_rdata == `PMSC_UNMAPPED))
   else $error("unmapped offset did not read all ones");

   // version offset returns the fixed code
   version_read_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (reg_addr == `PMSC_ADDR_VERSION) |-> (reg_rdata == VERSION_CODE))
   else $error("version offset returned a wrong code");

endmodule : pmsc_regs_top

// file: pmsc_host_model.sv
// two-wire bus master model for the serial port of the bank
`timescale 1ns/10ps
`include "pmsc_regs.svh"
module pmsc_host_model (
   // clock
   input wire logic clk_i,
   // bus lines, sda_i is the resolved wire
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   logic [7:0] r;
   logic a;
   // bus clock stands high between frames
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // a quarter of the 200 ns bus period is two reference clocks
   task automatic q(input int n);
      repeat (2 * n) @(posedge clk_i);
      #1;
   endtask : q
   // data changes only while the bus clock is low
   task automatic bit_io(input logic b, output logic s);
      sda_o = b;
      q(1);
      scl_o = 1'b1;
      q(1);
      s = sda_i;
      q(1);
      scl_o = 1'b0;
      q(1);
   endtask : bit_io
   // eight bits msb first, then the acknowledge slot
   task automatic xfer(input logic [7:0] d, input logic m, output logic ak);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r[i]);
      end
      bit_io(m, a);
      ak = !a;
   endtask : xfer
   // start, also used as repeated start
   task automatic start;
      sda_o = 1'b1;
      q(1);
      scl_o = 1'b1;
      q(1);
      sda_o = 1'b0;
      q(2);
      scl_o = 1'b0;
   endtask : start
   task automatic stop;
      sda_o = 1'b0;
      q(1);
      scl_o = 1'b1;
      q(1);
      sda_o = 1'b1;
      q(4);
   endtask : stop
   task automatic write(input logic [7:0] p, d, output logic ok);
      logic k1, k2, k3;
      start();
      xfer({`PMSC_BUS_ADDR, 1'b0}, 1'b1, k1);
      xfer(p, 1'b1, k2);
      xfer(d, 1'b1, k3);
      stop();
      ok = k1 & k2 & k3;
   endtask : write
   // pointer write, repeated start, one byte read closed by no-acknowledge
   task automatic read(input logic [7:0] p, output logic [7:0] d, output logic ok);
      logic k1, k2, k3, n;
      start();
      xfer({`PMSC_BUS_ADDR, 1'b0}, 1'b1, k1);
      xfer(p, 1'b1, k2);
      start();
      xfer({`PMSC_BUS_ADDR, 1'b1}, 1'b1, k3);
      xfer(8'hff, 1'b1, n);
      d = r;
      stop();
      ok = k1 & k2 & k3;
   endtask : read
endmodule : pmsc_host_model

// file: tb_pmic_status_control_regs.sv
// self-checking bench for the supply status and control register bank
`timescale 1ns/10ps
module tb_pmic_status_control_regs;
   logic ref_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [7:1] lv = 7'h00;
   logic [3:0] pn = 4'hf;
   logic dynamic_voltage_move = 1'b0;
   logic undervoltage_lockout = 1'b0;
   logic scl, hsda, dsda, doe, irq, ok;
   logic [5:1] en;
   logic [1:0] ph2, phc;
   logic [3:0] md;
   logic [7:0] rd;
   int error_cnt = 0;
   int total_checks = 0;
   // open-drain data wire with pull-up
   wire sda = hsda & ~(doe & ~dsda);
   pmsc_host_model host (.clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl), .sda_o(hsda));
   // version code is arbitrary
   pmsc_regs_top #(.VERSION_CODE(8'h3c)) dut (
      .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda),
      .sda_o(dsda), .sda_oe_o(doe), .power_fail_sense_i(lv[7]),
      .low_battery_sense_i(lv[6]), .buck1_output_low_i(lv[5]),
      .buck2_output_low_i(lv[4]), .core_buck_output_low_i(lv[3]),
      .linear_reg_two_low_i(lv[2]), .linear_reg_one_low_i(lv[1]),
      .dynamic_voltage_move_i(dynamic_voltage_move), .undervoltage_lockout_i(undervoltage_lockout),
      .buck1_enable_pin_i(pn[3]), .buck2_enable_pin_i(pn[2]),
      .core_buck_enable_pin_i(pn[1]), .linear_enable_pin_i(pn[0]),
      .buck1_en_o(en[5]), .buck2_en_o(en[4]), .core_buck_en_o(en[3]),
      .linear_reg_two_en_o(en[2]), .linear_reg_one_en_o(en[1]),
      .buck2_phase_o(ph2), .core_buck_phase_o(phc), .low_ripple_o(md[3]),
      .buck2_forced_fixed_freq_o(md[2]), .buck1_forced_fixed_freq_o(md[1]),
      .core_buck_forced_fixed_freq_o(md[0]), .int_n_o(irq));
   // clock, 25 ns period
   initial begin
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   task automatic wrap_up;
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [8:0] s, e);
      total_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("ERROR at %0t: saw %h, expected %h", $time, s, e);
      end
   endtask : chk
   // pins pass a synchroniser, so let them settle before looking
   task automatic st;
      repeat (10) @(posedge ref_clk_i);
      #1;
   endtask : st
   // a missing acknowledge shows up as a mismatch too
   task automatic wr(input logic [7:0] a, d);
      host.write(a, d, ok);
      chk({8'h00, ok}, 9'h001);
   endtask : wr
   task automatic rchk(input logic [7:0] a, e);
      host.read(a, rd, ok);
      chk({ok, rd}, {1'b1, e});
   endtask : rchk
   task automatic t_defaults;
      rchk(8'h00, 8'h3c);
      rchk(8'h02, 8'hc0);
      rchk(8'h03, 8'hff);
      rchk(8'h04, 8'hb1);
      chk({1'b0, ph2, phc, md}, 9'h0b1);
      chk({4'h0, en}, 9'h01f);
   endtask : t_defaults
   task automatic t_ro;
      wr(8'h00, 8'h00);
      rchk(8'h00, 8'h3c);
      wr(8'h01, 8'hff);
      rchk(8'h01, 8'h00);
      rchk(8'h09, 8'hff);
   endtask : t_ro
   task automatic t_status;
      lv = 7'h7f;
      st();
      chk({8'h00, irq}, 9'h000);
      rchk(8'h01, 8'hfe);
      dynamic_voltage_move = 1'b1;
      st();
      rchk(8'h01, 8'hf6);
      dynamic_voltage_move = 1'b0;
      pn = 4'h0;
      st();
      rchk(8'h01, 8'hc0);
      pn = 4'hf;
      lv = 7'h00;
      st();
   endtask : t_status
   task automatic t_enable;
      wr(8'h03, 8'h00);
      chk({4'h0, en}, 9'h000);
      pn = 4'h7;
      st();
      rchk(8'h03, 8'he1);
      pn = 4'hf;
      st();
      chk({4'h0, en}, 9'h010);
      pn = 4'he;
      st();
      rchk(8'h03, 8'he7);
      chk({4'h0, en}, 9'h010);
      pn = 4'hf;
      wr(8'h03, 8'hff);
   endtask : t_enable
   task automatic t_irq;
      lv[5] = 1'b1;
      wr(8'h02, 8'h00);
      st();
      chk({8'h00, irq}, 9'h000);
      wr(8'h02, 8'h20);
      chk({8'h00, irq}, 9'h001);
      wr(8'h02, 8'h00);
      rchk(8'h01, 8'h20);
      chk({8'h00, irq}, 9'h001);
      lv[5] = 1'b0;
   endtask : t_irq
   task automatic t_undervoltage_lockout;
      wr(8'h04, 8'h4e);
      chk({1'b0, ph2, phc, md}, 9'h04e);
      wr(8'h03, 8'h00);
      undervoltage_lockout = 1'b1;
      st();
      undervoltage_lockout = 1'b0;
      st();
      rchk(8'h02, 8'hc0);
      rchk(8'h03, 8'hff);
      rchk(8'h04, 8'hb1);
   endtask : t_undervoltage_lockout
   // main sequence
   initial begin
      repeat (5) @(posedge ref_clk_i);
      #1;
      nrst_i = 1'b1;
      st();
      t_defaults();
      t_ro();
      t_status();
      t_enable();
      t_irq();
      t_undervoltage_lockout();
      wrap_up();
   end
   // watchdog cuts a hang short
   initial begin
      repeat (100000) @(posedge ref_clk_i);
      error_cnt++;
      wrap_up();
   end
endmodule : tb_pmic_status_control_regs
